// ### hdl/scam_cmd_addr_mux.v
// SDRAM command sequencer and row/column address multiplexer
`timescale 1ns/1ps
`include "scam_defines.vh"
module scam_cmd_addr_mux (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        clkEn,
    input  wire [2:0]  colWidthSel,
    input  wire [1:0]  rowWidthSel,
    input  wire        bankPinSel,
    input  wire        accValid,
    input  wire        accWrite,
    input  wire [31:0] accAddr,
    input  wire [1:0]  accByteEn,
    output wire        accReady,
    output reg         accIssued_q,
    input  wire        modeLoadReq,
    input  wire [14:0] modeOpcode,
    output wire        modeLoadAck,
    input  wire        refreshReq,
    output wire        refreshAck,
    input  wire        selfRefreshReq,
    output wire        selfRefreshAck,
    output wire        selfRefreshActive,
    input  wire        closeAllReq,
    output wire        closeAllAck,
    input  wire        burstStopReq,
    output wire        burstStopAck,
    output wire        sdCsN,
    output wire        sdRasN,
    output wire        sdCasN,
    output wire        sdWeN,
    output reg  [1:0]  sdDqm_q,
    output reg  [14:0] sdAddr_q,
    output reg         sdCke_q,
    output wire [3:0]  bankOpen
);
    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam ST_IDLE   = 3'd0;
    localparam ST_LOOK   = 3'd1;
    localparam ST_DECIDE = 3'd2;
    localparam ST_OPEN   = 3'd3;
    localparam ST_RW     = 3'd4;
    localparam ST_WAIT   = 3'd5;
    localparam ST_REF    = 3'd6;
    localparam ST_SELF   = 3'd7;

    reg [2:0]  state_q;
    reg [2:0]  next_q;
    reg [1:0]  wait_q;
    reg [3:0]  cmd_q;
    reg        self_q;
    reg        write_q;
    reg [1:0]  byteEn_q;
    reg [31:0] addr_q;

    wire        tblValid;
    wire [12:0] tblRow;

    // ----------------------------------------------------------------
    // Width settings
    // ----------------------------------------------------------------
    // Out-of-range settings clamp to the widest legal mapping
    wire [2:0] colSel = (colWidthSel > `SCAM_COL_SEL_MAX) ?
                        `SCAM_COL_SEL_MAX : colWidthSel; // [R21]
    wire [1:0] rowSel = (rowWidthSel > `SCAM_ROW_SEL_MAX) ?
                        `SCAM_ROW_SEL_MAX : rowWidthSel; // [R21]

    wire [4:0] rowShift  = `SCAM_ROW_BASE + {2'b00, colSel}; // [R1] [R3]
    wire [4:0] bankShift = `SCAM_BANK_BASE + {2'b00, colSel}
                         + {3'b000, rowSel}; // [R1] [R5]

    // ----------------------------------------------------------------
    // Address slices
    // ----------------------------------------------------------------
    wire [31:0] rowShifted  = addr_q >> rowShift;
    wire [31:0] bankShifted = addr_q >> bankShift;
    wire [12:0] rowMask     = `SCAM_ROW_FULL >> (`SCAM_ROW_SEL_MAX - rowSel);
    wire [12:0] rowAddr     = rowShifted[12:0]; // [R3]
    wire [12:0] rowKey      = rowAddr & rowMask; // [R21]
    wire [1:0]  bankPins    = bankShifted[1:0]; // [R5]
    // Single bank pin: pin 14 still toggles but never selects a bank
    wire [1:0]  bankIdx     = bankPinSel ? bankPins
                                         : {1'b0, bankPins[0]}; // [R7] [R14]

    wire [14:0] rowPins = {bankPins, rowAddr}; // [R2] [R12]
    wire [14:0] colPins = {bankPins, addr_q[13:12], 1'b0,
                           addr_q[11:2]}; // [R4] [R6] [R13]

    wire rowHit = tblValid && (tblRow == rowKey);

    // ----------------------------------------------------------------
    // Request arbitration
    // ----------------------------------------------------------------
    wire idle = (state_q == ST_IDLE) && clkEn;

    assign selfRefreshAck = idle && selfRefreshReq;
    assign refreshAck     = idle && !selfRefreshReq && refreshReq;
    assign modeLoadAck    = idle && !selfRefreshReq && !refreshReq
                          && modeLoadReq;
    assign closeAllAck    = idle && !selfRefreshReq && !refreshReq
                          && !modeLoadReq && closeAllReq;
    assign burstStopAck   = idle && !selfRefreshReq && !refreshReq
                          && !modeLoadReq && !closeAllReq && burstStopReq;
    assign accReady       = idle && !selfRefreshReq && !refreshReq
                          && !modeLoadReq && !closeAllReq && !burstStopReq;

    wire accTake = accReady && accValid;

    // ----------------------------------------------------------------
    // Command pins
    // ----------------------------------------------------------------
    assign sdCsN  = cmd_q[3]; // [R8]
    assign sdRasN = cmd_q[2] | cmd_q[3];
    assign sdCasN = cmd_q[1] | cmd_q[3];
    assign sdWeN  = cmd_q[0] | cmd_q[3];

    assign selfRefreshActive = (state_q == ST_SELF);

    // ----------------------------------------------------------------
    // Bank table control
    // ----------------------------------------------------------------
    wire decide  = clkEn && (state_q == ST_DECIDE);
    wire openNow = clkEn && (state_q == ST_OPEN);
    wire setEn   = openNow || (decide && !tblValid);
    wire clrEn   = decide && tblValid && !rowHit;
    wire clrAll  = selfRefreshAck || refreshAck || closeAllAck;

    scam_bank_table uTable (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .clkEn     (clkEn),
        .rdBank    (bankIdx),
        .rdValid_q (tblValid),
        .rdRow_q   (tblRow),
        .setEn     (setEn),
        .setBank   (bankIdx),
        .setRow    (rowKey),
        .clrEn     (clrEn),
        .clrBank   (bankIdx),
        .clrAll    (clrAll),
        .openMask  (bankOpen)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= ST_IDLE;
            next_q      <= ST_IDLE;
            wait_q      <= 2'h0;
            cmd_q       <= `SCAM_CMD_INHIBIT;
            self_q      <= 1'b0;
            write_q     <= 1'b0;
            byteEn_q    <= 2'h0;
            addr_q      <= 32'h0000_0000;
            sdDqm_q     <= 2'h3;
            sdAddr_q    <= 15'h0000;
            sdCke_q     <= 1'b1;
            accIssued_q <= 1'b0;
        end else if (clkEn) begin
            cmd_q       <= `SCAM_CMD_NOP; // [R8]
            sdDqm_q     <= 2'h3;
            sdCke_q     <= 1'b1; // [R10]
            accIssued_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (selfRefreshAck || refreshAck) begin
                        // All banks must be closed before any refresh
                        cmd_q    <= `SCAM_CMD_CLOSE; // [R9]
                        sdAddr_q <= 15'h0400;
                        self_q   <= selfRefreshAck;
                        wait_q   <= `SCAM_GAP_CYC;
                        next_q   <= ST_REF;
                        state_q  <= ST_WAIT;
                    end else if (modeLoadAck) begin
                        cmd_q    <= `SCAM_CMD_MODE_LOAD; // [R8]
                        sdAddr_q <= modeOpcode;
                        wait_q   <= `SCAM_GAP_CYC;
                        next_q   <= ST_IDLE;
                        state_q  <= ST_WAIT;
                    end else if (closeAllAck) begin
                        cmd_q    <= `SCAM_CMD_CLOSE; // [R9]
                        sdAddr_q <= 15'h0400;
                        wait_q   <= `SCAM_GAP_CYC;
                        next_q   <= ST_IDLE;
                        state_q  <= ST_WAIT;
                    end else if (burstStopAck) begin
                        cmd_q <= `SCAM_CMD_BURST_END; // [R9]
                    end else if (accTake) begin
                        addr_q   <= accAddr;
                        write_q  <= accWrite;
                        byteEn_q <= accByteEn;
                        state_q  <= ST_LOOK;
                    end
                end
                ST_LOOK: begin
                    // Table read is registered; wait one cycle for it
                    state_q <= ST_DECIDE;
                end
                ST_DECIDE: begin
                    if (rowHit) begin
                        state_q <= ST_RW; // [R16]
                    end else if (!tblValid) begin
                        cmd_q    <= `SCAM_CMD_ROW_OPEN; // [R15] [R12]
                        sdAddr_q <= rowPins;
                        wait_q   <= `SCAM_GAP_CYC;
                        next_q   <= ST_RW;
                        state_q  <= ST_WAIT;
                    end else begin
                        cmd_q    <= `SCAM_CMD_CLOSE; // [R17] [R9]
                        sdAddr_q <= {bankPins, 13'h0000};
                        wait_q   <= `SCAM_GAP_CYC;
                        next_q   <= ST_OPEN;
                        state_q  <= ST_WAIT;
                    end
                end
                ST_OPEN: begin
                    cmd_q    <= `SCAM_CMD_ROW_OPEN; // [R17] [R12]
                    sdAddr_q <= rowPins;
                    wait_q   <= `SCAM_GAP_CYC;
                    next_q   <= ST_RW;
                    state_q  <= ST_WAIT;
                end
                ST_RW: begin
                    cmd_q       <= write_q ? `SCAM_CMD_STORE
                                           : `SCAM_CMD_READ; // [R9]
                    sdAddr_q    <= colPins; // [R13]
                    sdDqm_q     <= ~byteEn_q; // [R13]
                    accIssued_q <= 1'b1;
                    state_q     <= ST_IDLE;
                end
                ST_WAIT: begin
                    if (wait_q <= 2'h1) begin
                        state_q <= next_q;
                    end else begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                ST_REF: begin
                    cmd_q   <= `SCAM_CMD_REFRESH; // [R9] [R11]
                    sdCke_q <= !self_q; // [R10] [R11]
                    if (self_q) begin
                        state_q <= ST_SELF;
                    end else begin
                        wait_q  <= `SCAM_GAP_CYC;
                        next_q  <= ST_IDLE;
                        state_q <= ST_WAIT;
                    end
                end
                ST_SELF: begin
                    // Memory refreshes itself while clock enable stays low
                    if (selfRefreshReq) begin
                        sdCke_q <= 1'b0; // [R10]
                    end else begin
                        self_q  <= 1'b0;
                        wait_q  <= `SCAM_GAP_CYC;
                        next_q  <= ST_IDLE;
                        state_q <= ST_WAIT;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ### pkg/scam_defines.vh
// Constants for the SDRAM command and address multiplexer
//
// Contract
// R1: Address muxing picked from column, row, bank settings
// R2: Fifteen address pins serve row and column phases
// R3: Row phase drives thirteen bits from 2+colwidth
// R4: Column phase: bits 2-11, 12, 13, command bit
// R5: Pins 13,14 carry bits above the row field
// R6: Pin 10 fixed by access type in column phase
// R7: Bank pin setting picks one or two bank pins
// R8: Encode inhibit, nop, mode load, row open
// R9: Encode read, store, stop, close, close-all, refresh
// R10: Clock enable high except self-refresh entry
// R11: Refresh encoding: auto or self by clock enable
// R12: Row open: row on 0-12, bank 13-14
// R13: Read/store: column 0-9, bank 13-14, byte masks
// R14: Two or four banks, one open row each
// R15: Closed bank: row open, then access
// R16: Matching open row: access directly
// R17: Other row open: close, open, then access
// R18: Software sets refresh within max row-active time
// R19: Without refresh, software limits bank active time
// R20: Per-bank valid flag and open row kept
// R21: Column 8-12 and row 11-13 widths accepted
`ifndef SCAM_DEFINES_VH
`define SCAM_DEFINES_VH

// ----------------------------------------------------------------
// Command codes {csN, rasN, casN, weN}
// ----------------------------------------------------------------
`define SCAM_CMD_INHIBIT   4'h8
`define SCAM_CMD_NOP       4'h7
`define SCAM_CMD_MODE_LOAD 4'h0
`define SCAM_CMD_ROW_OPEN  4'h3
`define SCAM_CMD_READ      4'h5
`define SCAM_CMD_STORE     4'h4
`define SCAM_CMD_BURST_END 4'h6
`define SCAM_CMD_CLOSE     4'h2
`define SCAM_CMD_REFRESH   4'h1

// ----------------------------------------------------------------
// Address mapping
// ----------------------------------------------------------------
`define SCAM_COL_SEL_MAX   3'h4
`define SCAM_ROW_SEL_MAX   2'h2
`define SCAM_ROW_BASE      5'h0a
`define SCAM_BANK_BASE     5'h15
`define SCAM_ROW_BITS      13
`define SCAM_ROW_FULL      13'h1fff
`define SCAM_BANKS         4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCAM_GAP_CYC       2'h1

`endif

// ### hdl/scam_bank_table.v
// Per-bank open-row table with registered lookup
`timescale 1ns/1ps
`include "scam_defines.vh"
module scam_bank_table (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire        clkEn,
    input  wire [1:0]  rdBank,
    output reg         rdValid_q,
    output reg  [12:0] rdRow_q,
    input  wire        setEn,
    input  wire [1:0]  setBank,
    input  wire [12:0] setRow,
    input  wire        clrEn,
    input  wire [1:0]  clrBank,
    input  wire        clrAll,
    output wire [3:0]  openMask
);
    reg [12:0] rowMem [0:`SCAM_BANKS-1];
    reg [3:0]  valid_q;

    assign openMask = valid_q;

    // ----------------------------------------------------------------
    // One entry per bank
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SCAM_BANKS; g = g + 1) begin : gEntry
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    valid_q[g] <= 1'b0;
                    rowMem[g]  <= 13'h0000;
                end else if (clkEn) begin
                    if (clrAll || (clrEn && clrBank == g)) begin
                        valid_q[g] <= 1'b0; // [R20]
                    end else if (setEn && setBank == g) begin
                        valid_q[g] <= 1'b1; // [R14] [R20]
                        rowMem[g]  <= setRow;
                    end
                end
            end
        end
    endgenerate

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdValid_q <= 1'b0;
            rdRow_q   <= 13'h0000;
        end else if (clkEn) begin
            rdValid_q <= valid_q[rdBank];
            rdRow_q   <= rowMem[rdBank];
        end
    end
endmodule

// ### verification/scam_cmd_addr_mux_chk.sv
// Assertion checker for the SDRAM command and address multiplexer
`timescale 1ns/1ps
`include "scam_defines.vh"
module scam_cmd_addr_mux_chk (
    input wire        sys_clk,
    input wire        rstn,
    input wire        accValid,
    input wire        accReady,
    input wire        accIssued_q,
    input wire        modeLoadReq,
    input wire [14:0] modeOpcode,
    input wire        modeLoadAck,
    input wire        refreshReq,
    input wire        refreshAck,
    input wire        selfRefreshReq,
    input wire        selfRefreshAck,
    input wire        sdCsN,
    input wire        sdRasN,
    input wire        sdCasN,
    input wire        sdWeN,
    input wire [1:0]  sdDqm_q,
    input wire [14:0] sdAddr_q,
    input wire        sdCke_q
);
    // ------------------------------------------------------------
    // Command relations
    // ------------------------------------------------------------
    wire [3:0] cmd = {sdCsN, sdRasN, sdCasN, sdWeN};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_take; accValid && accReady |-> ##[4:7] accIssued_q; endproperty
    a_take: assert property (p_take) else $error("access late");
    property p_issue;
        accIssued_q |-> (cmd == `SCAM_CMD_READ || cmd == `SCAM_CMD_STORE) && !sdAddr_q[10];
    endproperty
    a_issue: assert property (p_issue) else $error("bad access command");
    property p_dqm; !accIssued_q |-> sdDqm_q == 2'h3; endproperty
    a_dqm: assert property (p_dqm) else $error("lane mask outside access");
    property p_open; cmd == `SCAM_CMD_ROW_OPEN |-> ##2 accIssued_q; endproperty
    a_open: assert property (p_open) else $error("no access after open");
    property p_close; cmd == `SCAM_CMD_CLOSE && !sdAddr_q[10] |-> ##2 cmd == `SCAM_CMD_ROW_OPEN;
    endproperty
    a_close: assert property (p_close) else $error("no open after close");
    property p_mode;
        modeLoadReq && modeLoadAck |=> cmd == `SCAM_CMD_MODE_LOAD && sdAddr_q == $past(modeOpcode);
    endproperty
    a_mode: assert property (p_mode) else $error("bad mode load");
    property p_ref;
        refreshReq && refreshAck |=> cmd == `SCAM_CMD_CLOSE && sdAddr_q[10]
            ##2 cmd == `SCAM_CMD_REFRESH && sdCke_q;
    endproperty
    a_ref: assert property (p_ref) else $error("bad refresh sequence");
    property p_self;
        selfRefreshReq && selfRefreshAck |-> ##3 cmd == `SCAM_CMD_REFRESH && !sdCke_q;
    endproperty
    a_self: assert property (p_self) else $error("bad self refresh entry");
    property p_cke; !sdCke_q |-> cmd == `SCAM_CMD_REFRESH || cmd == `SCAM_CMD_NOP; endproperty
    a_cke: assert property (p_cke) else $error("clock enable low on command");
endmodule

bind scam_cmd_addr_mux scam_cmd_addr_mux_chk scam_cmd_addr_mux_chk_i (
    .sys_clk(sys_clk), .rstn(rstn), .accValid(accValid), .accReady(accReady),
    .accIssued_q(accIssued_q), .modeLoadReq(modeLoadReq), .modeOpcode(modeOpcode),
    .modeLoadAck(modeLoadAck), .refreshReq(refreshReq), .refreshAck(refreshAck),
    .selfRefreshReq(selfRefreshReq), .selfRefreshAck(selfRefreshAck), .sdCsN(sdCsN),
    .sdRasN(sdRasN), .sdCasN(sdCasN), .sdWeN(sdWeN), .sdDqm_q(sdDqm_q),
    .sdAddr_q(sdAddr_q), .sdCke_q(sdCke_q));

// ### verification/scam_sdram_model.sv
// Behavioural SDRAM chip that checks the command stream it receives
`timescale 1ns/1ps
`include "scam_defines.vh"
module scam_sdram_model (
    input  wire         sys_clk,
    input  wire         rstn,
    input  wire         bankPinSel,
    input  wire         sdCsN,
    input  wire         sdRasN,
    input  wire         sdCasN,
    input  wire         sdWeN,
    input  wire         sdCke_q,
    input  wire  [14:0] sdAddr_q,
    output logic [15:0] errCount
);
    wire [3:0] cmd = {sdCsN, sdRasN, sdCasN, sdWeN};
    wire [1:0] bank = {bankPinSel & sdAddr_q[14], sdAddr_q[13]};
    logic [3:0] active;
    logic       selfMode;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            active <= 4'h0;
            selfMode <= 1'b0;
            errCount <= 16'h0000;
        end else if (selfMode) begin
            // Only clock enable returning high ends self refresh
            if (sdCke_q)
                selfMode <= 1'b0;
            else if (cmd != `SCAM_CMD_NOP)
                errCount <= errCount + 16'h0001;
        end else begin
            case (cmd)
                `SCAM_CMD_ROW_OPEN: begin
                    if (active[bank])
                        errCount <= errCount + 16'h0001;
                    active[bank] <= 1'b1;
                end
                `SCAM_CMD_READ, `SCAM_CMD_STORE: begin
                    if (!active[bank] || sdAddr_q[10])
                        errCount <= errCount + 16'h0001;
                end
                `SCAM_CMD_CLOSE: begin
                    if (sdAddr_q[10])
                        active <= 4'h0;
                    else
                        active[bank] <= 1'b0;
                end
                `SCAM_CMD_REFRESH, `SCAM_CMD_MODE_LOAD: begin
                    if (active != 4'h0)
                        errCount <= errCount + 16'h0001;
                    selfMode <= cmd == `SCAM_CMD_REFRESH && !sdCke_q;
                end
                default: ;
            endcase
        end
    end
endmodule

// ### verification/scam_cmd_addr_mux_tb.sv
// Self-checking testbench for the SDRAM command and address multiplexer
`timescale 1ns/1ps
`include "scam_defines.vh"
module scam_cmd_addr_mux_tb;
    logic        sys_clk = 0;
    logic        rstn = 0;
    logic [2:0]  colWidthSel = 0;
    logic [1:0]  rowWidthSel = 0;
    logic        bankPinSel = 0;
    logic        accValid = 0;
    logic        accWrite = 0;
    logic [31:0] accAddr = 0;
    logic [1:0]  accByteEn = 0;
    logic [3:0]  mReq = 0;
    logic        selfReq = 0;
    logic        clkEn = 1;
    logic [14:0] modeOpcode = 0;
    logic [31:0] seed = 32'h0000_005a;
    logic [31:0] a, b, x;
    wire  [3:0]  mAck, bankOpen;
    wire  [1:0]  sdDqm_q;
    wire  [14:0] sdAddr_q;
    wire  [15:0] errCount;
    wire         accReady, accIssued_q, selfAck, selfActive, sdCsN, sdRasN, sdCasN, sdWeN;
    wire         sdCke_q;
    wire  [3:0]  cmd = {sdCsN, sdRasN, sdCasN, sdWeN};
    int          bad_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          rs, bs, rw;
    bit          opn[4];
    int          openRow[4];

    scam_cmd_addr_mux scam_cmd_addr_mux_i (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
        .colWidthSel(colWidthSel), .rowWidthSel(rowWidthSel), .bankPinSel(bankPinSel),
        .accValid(accValid), .accWrite(accWrite), .accAddr(accAddr), .accByteEn(accByteEn),
        .accReady(accReady), .accIssued_q(accIssued_q), .modeLoadReq(mReq[3]),
        .modeOpcode(modeOpcode), .modeLoadAck(mAck[3]), .refreshReq(mReq[0]),
        .refreshAck(mAck[0]), .selfRefreshReq(selfReq), .selfRefreshAck(selfAck),
        .selfRefreshActive(selfActive), .closeAllReq(mReq[1]), .closeAllAck(mAck[1]),
        .burstStopReq(mReq[2]), .burstStopAck(mAck[2]), .sdCsN(sdCsN), .sdRasN(sdRasN),
        .sdCasN(sdCasN), .sdWeN(sdWeN), .sdDqm_q(sdDqm_q), .sdAddr_q(sdAddr_q),
        .sdCke_q(sdCke_q), .bankOpen(bankOpen));
    scam_sdram_model scam_sdram_model_i (.sys_clk(sys_clk), .rstn(rstn), .bankPinSel(bankPinSel),
        .sdCsN(sdCsN), .sdRasN(sdRasN), .sdCasN(sdCasN), .sdWeN(sdWeN), .sdCke_q(sdCke_q),
        .sdAddr_q(sdAddr_q), .errCount(errCount));

    always #50 sys_clk = ~sys_clk;
    // Hang guard, well above the expected run of under two thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Maintenance: 0 refresh, 1 close all, 2 burst stop, 3 mode load
    task maint(input int k);
        @(posedge sys_clk);
        mReq[k] <= 1'b1;
        modeOpcode <= rnd() >> 17;
        do @(negedge sys_clk); while (mAck[k] !== 1'b1);
        @(posedge sys_clk);
        mReq[k] <= 1'b0;
        @(negedge sys_clk);
        chk(cmd, k == 2 ? `SCAM_CMD_BURST_END : (k == 3 ? `SCAM_CMD_MODE_LOAD : `SCAM_CMD_CLOSE));
        if (k == 3)
            chk(sdAddr_q, modeOpcode);
        if (k < 2)
            chk(sdAddr_q[10], 1);
        @(negedge sys_clk);
        chk(cmd, `SCAM_CMD_NOP);
        if (k < 2)
            opn = '{0, 0, 0, 0};
        if (k < 2)
            chk(bankOpen, 0);
        @(negedge sys_clk);
        if (k == 0)
            chk({cmd, sdCke_q}, {`SCAM_CMD_REFRESH, 1'b1});
    endtask
    // One access; the bench's own bank table predicts the command sequence
    task access(input logic [31:0] ad, input logic wr, input logic [1:0] be);
        int bk, row, last, kind, bp;
        logic [3:0] ec;
        bp = (ad >> bs) & 3;
        bk = bankPinSel ? bp : bp & 1;
        row = (ad >> rs) & ((1 << rw) - 1);
        kind = !opn[bk] ? 1 : (openRow[bk] == row ? 0 : 2);
        last = kind == 0 ? 4 : (kind == 1 ? 5 : 7);
        opn[bk] = 1;
        openRow[bk] = row;
        @(posedge sys_clk);
        accValid <= 1'b1;
        accWrite <= wr;
        accAddr <= ad;
        accByteEn <= be;
        do @(negedge sys_clk); while (accReady !== 1'b1);
        @(posedge sys_clk);
        accValid <= 1'b0;
        for (int n = 1; n <= last; n++) begin
            @(negedge sys_clk);
            ec = kind == 2 && n == 3 ? `SCAM_CMD_CLOSE : `SCAM_CMD_NOP;
            if (kind > 0 && n == last - 2)
                ec = `SCAM_CMD_ROW_OPEN;
            if (n == last)
                ec = wr ? `SCAM_CMD_STORE : `SCAM_CMD_READ;
            chk(cmd, ec);
            chk(accIssued_q, n == last);
            chk(sdDqm_q, n == last ? {30'h0, ~be} : 32'h0000_0003);
            if (ec == `SCAM_CMD_ROW_OPEN)
                chk(sdAddr_q, (bp << 13) | ((ad >> rs) & 32'h0000_1fff));
            if (ec == `SCAM_CMD_CLOSE)
                chk({sdAddr_q[14:13], sdAddr_q[10]}, bp << 1);
            if (n == last)
                chk(sdAddr_q, (bp << 13) | (((ad >> 12) & 3) << 11) | ((ad >> 2) & 32'h0000_03ff));
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (11) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({sdCsN, sdDqm_q, sdCke_q, bankOpen, sdAddr_q}, 32'h0078_0000);
        @(posedge sys_clk);
        rstn <= 1'b1;
        maint(0);
        maint(3);
        maint(2);
        maint(1);
        @(posedge sys_clk);
        selfReq <= 1'b1;
        do @(negedge sys_clk); while (selfAck !== 1'b1);
        repeat (3) @(negedge sys_clk);
        chk({cmd, sdCke_q}, {`SCAM_CMD_REFRESH, 1'b0});
        repeat (5) @(negedge sys_clk);
        chk({sdCke_q, selfActive}, 2'h1);
        @(posedge sys_clk);
        selfReq <= 1'b0;
        clkEn <= 1'b0;
        repeat (3) @(negedge sys_clk);
        // Frozen by the clock enable: exit request not yet seen
        chk({sdCke_q, selfActive, accReady}, 3'h2);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({sdCke_q, accReady}, 2'h3);
        $display("test maintenance done");
        for (int c = 0; c < 8; c++) begin
            for (int r = 0; r < 4; r++) begin
                rs = 10 + (c > 4 ? 4 : c);
                rw = 11 + (r > 2 ? 2 : r);
                bs = rs + rw;
                @(posedge sys_clk);
                colWidthSel <= 3'(c);
                rowWidthSel <= 2'(r);
                bankPinSel <= c % 2 == 1;
                maint(r % 2); // Clears every open row between configurations
                a = rnd();
                if (c % 2 == 0)
                    a = a & ~(32'h1 << (bs + 1));
                for (int i = 0; i < 5; i++) begin
                    x = rnd();
                    b = i == 1 ? a ^ (x & ((32'h1 << rs) - 32'h4)) : a;
                    if (i == 2)
                        b = a ^ (32'h1 << rs);
                    if (i == 3)
                        b = a ^ (32'h1 << bs);
                    access(b, x[0], x[2:1]);
                end
            end
            $display("test column setting %0d done", c);
        end
        chk(errCount, 0);
        results();
    end
endmodule
